// ===== rtl/leb_defines.vh
// Register offsets, field positions and reset values for the blanking block
// Assumes inclusion by bare name from rtl/
`ifndef LEB_DEFINES_VH
`define LEB_DEFINES_VH
`define LEB_CTRL_OFFS 4'h0
`define LEB_AUX_OFFS 4'h4
`define LEB_DUR_OFFS 4'h8
`define LEB_STAT_OFFS 4'hc
`define LEB_CTRL_RESET 16'h0000
`define LEB_CTRL_MASK 16'hfc3f
`define LEB_AUX_RESET 4'h0
`define LEB_DUR_RESET 16'h0000
`define LEB_HRISE_BIT 15
`define LEB_HFALL_BIT 14
`define LEB_LRISE_BIT 13
`define LEB_LFALL_BIT 12
`define LEB_FLT_BIT 11
`define LEB_CL_BIT 10
`define LEB_EXTH_BIT 5
`define LEB_EXTL_BIT 4
`define LEB_HSH_BIT 3
`define LEB_HSL_BIT 2
`define LEB_LSH_BIT 1
`define LEB_LSL_BIT 0
`define LEB_RESP_OKAY 2'b00
`define LEB_RESP_SLVERR 2'b10
`endif

// ===== rtl/leb_sync2.v
// Two-flop synchroniser for a bus of asynchronous levels
// Assumes a single destination clock
`timescale 1ns/10ps
module leb_sync2 #(
    parameter W = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // leb_sync2

// ===== rtl/leb_blanking.v
// Leading-edge and state blanking for one PWM pair, with AXI4-Lite registers
// Assumes PWM outputs, fault and current-limit inputs and blanking sources are asynchronous pins
// Contract
// - Bits 15..12 enable four edge triggers
// - Disabled edge never starts blanking
// - Bit 11 blanks the fault input
// - Bit 10 blanks the current-limit input
// - Bit 5 masks while source high
// - Bit 4 masks while source low
// - Bits 3,2 mask on high-side level
// - Bits 1,0 mask on low-side level
// - Four-bit select picks external blanking source
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "leb_defines.vh"
module leb_blanking #(
    parameter NSRC = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire pwm_high_side_out,
    input wire pwm_low_side_out,
    input wire [NSRC-1:0] blank_sources,
    input wire fault_in,
    input wire curlim_in,
    output reg fault_out,
    output reg curlim_out,
    output reg blank_active
);
    reg [15:0] ctrl_r;
    reg [3:0] blank_source_select;
    reg [15:0] dur_r;
    reg [15:0] cnt_r;
    reg [3:0] aw_addr_r;
    reg aw_full_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_full_r;
    reg hs_d_r;
    reg ls_d_r;
    wire [NSRC+3:0] sync_q;
    wire hs;
    wire ls;
    wire flt_s;
    wire cl_s;
    wire [NSRC-1:0] src_s;
    wire ext_sig;
    wire trig;
    wire edge_blank;
    wire state_blank;
    wire do_wr;

    // Every asynchronous input passes two flops before use
    leb_sync2 #(.W(NSRC + 4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({blank_sources, curlim_in, fault_in, pwm_low_side_out, pwm_high_side_out}),
        .q(sync_q)
    );
    assign hs = sync_q[0];
    assign ls = sync_q[1];
    assign flt_s = sync_q[2];
    assign cl_s = sync_q[3];
    assign src_s = sync_q[NSRC+3:4];
    assign ext_sig = src_s[blank_source_select];

    // Byte-lane merge, used for the control and duration registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // Address and data are latched separately so either may come first
    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_full_r && w_full_r && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= 4'h0;
            aw_full_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LEB_RESP_OKAY;
            ctrl_r <= `LEB_CTRL_RESET;
            blank_source_select <= `LEB_AUX_RESET;
            dur_r <= `LEB_DUR_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_full_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_full_r <= 1'b1;
            end
            if (do_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `LEB_RESP_OKAY;
                case ({aw_addr_r[3:2], 2'b00})
                    `LEB_CTRL_OFFS: begin
                        // Unimplemented bits 9..6 stay zero
                        ctrl_r <= merge16(ctrl_r, w_data_r, w_strb_r) & `LEB_CTRL_MASK;
                    end
                    `LEB_AUX_OFFS: begin
                        if (w_strb_r[0]) begin
                            blank_source_select <= w_data_r[3:0];
                        end
                    end
                    `LEB_DUR_OFFS: begin
                        dur_r <= merge16(dur_r, w_data_r, w_strb_r);
                    end
                    `LEB_STAT_OFFS: begin
                        s_axi_bresp <= `LEB_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `LEB_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `LEB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `LEB_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `LEB_CTRL_OFFS: s_axi_rdata <= {16'h0000, ctrl_r};
                `LEB_AUX_OFFS: s_axi_rdata <= {28'h0000000, blank_source_select};
                `LEB_DUR_OFFS: s_axi_rdata <= {16'h0000, dur_r};
                `LEB_STAT_OFFS: s_axi_rdata <= {12'h000, cnt_r, 1'b0, blank_active, ls, hs};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `LEB_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Edge triggers, each gated by its own enable
    assign trig = (ctrl_r[`LEB_HRISE_BIT] && hs && !hs_d_r) ||
                  (ctrl_r[`LEB_HFALL_BIT] && !hs && hs_d_r) ||
                  (ctrl_r[`LEB_LRISE_BIT] && ls && !ls_d_r) ||
                  (ctrl_r[`LEB_LFALL_BIT] && !ls && ls_d_r);

    // Counter loads the duration and counts down to zero; a new edge reloads it
    always @(posedge aclk) begin
        if (!aresetn) begin
            hs_d_r <= 1'b0;
            ls_d_r <= 1'b0;
            cnt_r <= 16'h0000;
        end else begin
            hs_d_r <= hs;
            ls_d_r <= ls;
            if (trig) begin
                cnt_r <= dur_r;
            end else if (cnt_r != 16'h0000) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end
    assign edge_blank = (cnt_r != 16'h0000);

    assign state_blank = (ctrl_r[`LEB_EXTH_BIT] && ext_sig) ||
                         (ctrl_r[`LEB_EXTL_BIT] && !ext_sig) ||
                         (ctrl_r[`LEB_HSH_BIT] && hs) ||
                         (ctrl_r[`LEB_HSL_BIT] && !hs) ||
                         (ctrl_r[`LEB_LSH_BIT] && ls) ||
                         (ctrl_r[`LEB_LSL_BIT] && !ls);

    // Outputs registered; one cycle added after the synchroniser
    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_out <= 1'b0;
            curlim_out <= 1'b0;
            blank_active <= 1'b0;
        end else begin
            blank_active <= edge_blank || state_blank;
            fault_out <= flt_s && !(state_blank || (ctrl_r[`LEB_FLT_BIT] && edge_blank));
            curlim_out <= cl_s && !(state_blank || (ctrl_r[`LEB_CL_BIT] && edge_blank));
        end
    end
endmodule // leb_blanking

// ===== tb/leb_chk_asserts.sv
// Port checks for the blanking block
// Assumes binding onto leb_blanking
`timescale 1ns/10ps
module leb_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire fault_in,
    input wire curlim_in,
    input wire fault_out,
    input wire curlim_out,
    input wire blank_active
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
resp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
fault_pass_a: assert property (!fault_in [*4] |-> !fault_out)
    else $error("fault out without fault in");
curlim_pass_a: assert property (!curlim_in [*4] |-> !curlim_out)
    else $error("limit out without limit in");
// Outputs lag the pins by three edges; with no blanking in force they follow exactly
flt_unblanked_a: assert property (!blank_active |-> fault_out == $past(fault_in, 3))
    else $error("fault masked without blanking");
cl_unblanked_a: assert property (!blank_active |-> curlim_out == $past(curlim_in, 3))
    else $error("limit masked without blanking");
cover property (s_axi_bvalid && s_axi_bready);
cover property (s_axi_rvalid && !s_axi_rready);
cover property (fault_in && !fault_out);
endmodule // leb_chk
bind leb_blanking leb_chk leb_chk_i (.*);

// ===== tb/leb_far.sv
// Far side: PWM pair, fault and limit sources, blanking lines
// Assumes bench commands change just after a rising edge
`timescale 1ns/10ps
module leb_far (
    input wire aclk,
    input wire [4:0] cmd,
    input wire [3:0] sel,
    output reg hs = 1'b0,
    output reg ls = 1'b0,
    output reg [15:0] src = 16'h0000,
    output reg flt = 1'b0,
    output reg cl = 1'b0
);
always @(posedge aclk) begin
    hs <= cmd[0];
    ls <= cmd[1];
    // Unselected lines carry the inverse so a wrong pick shows
    src <= cmd[2] ? (16'h0001 << sel) : ~(16'h0001 << sel);
    flt <= cmd[3];
    cl <= cmd[4];
end
endmodule // leb_far

// ===== tb/testbench.sv
// Self-checking bench for leb_blanking over AXI4-Lite
// Assumes leb_far drives the pins with source 3 selected
`timescale 1ns/10ps
module testbench;
reg aclk = 0;
reg aresetn = 0;
reg [3:0] awaddr = 0, araddr = 0;
reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
reg [31:0] wdata = 0, rd;
reg [1:0] rp;
reg [4:0] cmd = 0;
wire awready, wready, bvalid, arready, rvalid, hs, ls, flt, cl, fo, co, ba;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [15:0] src;
integer miscompares = 0, checks_done = 0, cyc = 0, k;
always #4 aclk = ~aclk;
leb_far leb_far_i (.aclk(aclk), .cmd(cmd), .sel(4'h3), .hs(hs), .ls(ls), .src(src), .flt(flt), .cl(cl));
leb_blanking leb_blanking_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_high_side_out(hs),
    .pwm_low_side_out(ls), .blank_sources(src), .fault_in(flt), .curlim_in(cl), .fault_out(fo),
    .curlim_out(co), .blank_active(ba));
task close_out;
begin
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
begin
    checks_done = checks_done + 1;
    if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
end
endtask
// Ready is raised late on purpose so the answer has to stand
task wr(input [3:0] a, input [31:0] d);
reg ha, hw, h;
begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    h = 0;
    while (!h) begin
        @(negedge aclk);
        ha = awvalid && awready;
        hw = wvalid && wready;
        h = bvalid && bready;
        @(posedge aclk);
        if (ha)
            awvalid <= 1'b0;
        if (hw)
            wvalid <= 1'b0;
        bready <= bvalid && !h;
    end
end
endtask
task rdr(input [3:0] a);
reg ha, h;
begin
    araddr <= a;
    arvalid <= 1'b1;
    h = 0;
    while (!h) begin
        @(negedge aclk);
        ha = arvalid && arready;
        h = rvalid && rready;
        rd = rdata;
        rp = rresp;
        @(posedge aclk);
        if (ha)
            arvalid <= 1'b0;
        rready <= rvalid && !h;
    end
end
endtask
task pins(input [39:0] nm, input integer n, input [1:0] exp);
begin
    repeat (n) @(posedge aclk);
    @(negedge aclk);
    // Blank indicator must be up exactly when either output is masked
    chk(nm, {ba, fo, co}, {exp != 2'b11, exp});
    @(posedge aclk);
end
endtask
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        miscompares = miscompares + 1;
        close_out;
    end
end
initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 4; k = k + 1) begin
        rdr({k[1:0], 2'b00});
        chk("reset", rd, 0);
        chk("rresp", rp, 0);
    end
    wr(4'h0, 32'hffffffff);
    rdr(4'h0);
    chk("ctrl", rd, 32'hfc3f);
    wr(4'h4, 32'hff);
    rdr(4'h4);
    chk("sel", rd, 32'hf);
    wr(4'h4, 32'h3);
    wr(4'h8, 32'ha);
    // Each state enable masks at its own level and passes at the other
    for (k = 0; k < 6; k = k + 1) begin
        wr(4'h0, 32'h1 << k);
        cmd <= {2'b11, {3{k[0]}}};
        pins("mask", 6, 2'b00);
        cmd <= {2'b11, {3{~k[0]}}};
        pins("pass", 6, 2'b11);
    end
    // One edge enabled; the same edge on the other pin must not blank
    for (k = 0; k < 4; k = k + 1) begin
        wr(4'h0, (32'h8000 >> k) | (k[0] ? 32'h800 : 32'h400));
        cmd <= {3'b110, {2{k[0]}}};
        pins("idle", 20, 2'b11);
        // Move only the pin whose edges are not enabled
        cmd <= {3'b110, k[1] ? {k[0], ~k[0]} : {~k[0], k[0]}};
        pins("other", 7, 2'b11);
        cmd <= {3'b110, {2{~k[0]}}};
        pins("edge", 5, {~k[0], k[0]});
        pins("end", 12, 2'b11);
    end
    // A second edge inside the interval must restart it, outlasting the first
    wr(4'h0, 32'hc400);
    cmd <= 5'b11001;
    pins("first", 5, 2'b10);
    cmd <= 5'b11000;
    pins("again", 10, 2'b10);
    pins("done", 6, 2'b11);
    close_out;
end
endmodule // testbench
